// file: core/rafc_pkg.sv
// Package for the regeneration avoidance frequency control block.
// Assumes one 20 MHz control clock and an AXI4-Lite register bus.
package rafc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_MODE  = 8'h00;
	localparam logic [7:0] OFS_THR   = 8'h04;
	localparam logic [7:0] OFS_LIMIT = 8'h08;
	localparam logic [7:0] OFS_VGAIN = 8'h0c;
	localparam logic [7:0] OFS_FGAIN = 8'h10;
	localparam logic [7:0] OFS_FMAX  = 8'h14;
	localparam logic [7:0] OFS_VIS   = 8'h18;
	localparam logic [7:0] OFS_STATE = 8'h1c;
	localparam logic [7:0] OFS_IRQST = 8'h20;
	localparam logic [7:0] OFS_MASK  = 8'h24;
	// Mode encodings
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_ALWAYS = 2'h1;
	localparam logic [1:0] MODE_STEADY = 2'h2;
	// Setting ranges; frequency in 0.01 Hz, limit in 0.1 Hz, voltage in V
	localparam logic [9:0]  THR_MIN     = 10'h12c;
	localparam logic [9:0]  THR_MAX     = 10'h320;
	localparam logic [15:0] LIMIT_MAX   = 16'h0064;
	localparam logic [15:0] LIMIT_NONE  = 16'h270f;
	localparam logic [7:0]  GAIN_MAX    = 8'hc8;
	localparam logic [25:0] GAIN_DIV    = 26'h2710;
	localparam logic [15:0] DECAY_STEP  = 16'h000a;
	// Values after reset
	localparam logic [1:0]  RST_MODE  = 2'h0;
	localparam logic [9:0]  RST_THR   = 10'h190;
	localparam logic [15:0] RST_LIMIT = 16'h003c;
	localparam logic [7:0]  RST_VGAIN = 8'h64;
	localparam logic [7:0]  RST_FGAIN = 8'h64;
	localparam logic [15:0] RST_FMAX  = 16'h2ee0;
	localparam logic [1:0]  RST_VIS   = 2'h0;
	// Status and state bit positions, bus response codes
	localparam int ST_START = 0;
	localparam int ST_HOLD  = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Ramp generator status of the current control cycle
	typedef struct packed {
		logic accel;
		logic steady;
		logic decel;
	} rafc_ramp_type;

	// Software settings
	typedef struct packed {
		logic [1:0]  mode;
		logic [9:0]  thr;
		logic [15:0] limit;
		logic [7:0]  vgain;
		logic [7:0]  fgain;
		logic [15:0] fmax;
	} rafc_cfg_type;
endpackage : rafc_pkg

// file: core/rafc_top.sv
// Regeneration avoidance: raises the frequency command on high DC bus voltage.
// Assumes bus voltage, sample strobe and ramp status come from logic on aclk.
// Behaviour
// - Mode 0 off, 1 always, 2 steady only
// - Raise frequency while bus voltage reaches threshold
// - Threshold accepted from 300 to 800 V
// - Accel/steady raise capped at base plus limit
// - Decel overshoot holds limit until half limit
// - Raised frequency never exceeds maximum frequency
// - Limit value 9999 removes the cap
// - Voltage gain 0 to 200 percent, 100 reset
// - Separate frequency gain 0 to 200 percent
// - Active shows stall indication and alarm output
// - Active also engages stall prevention
// - Settings writable only with visibility zero
// - Low threshold keeps avoidance active, raising
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
module rafc_top
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   sample_tick,
	input  wire logic [9:0]             bus_voltage,
	input  wire logic [15:0]            base_frequency,
	input  wire rafc_pkg::rafc_ramp_type ramp_status,
	output logic [15:0]                 frequency_command,
	output logic                        ov_stall_indication,
	output logic                        stall_alarm_output,
	output logic                        stall_prevent_request,
	output logic                        irq
);
	import rafc_pkg::*;

	rafc_cfg_type cfg_q;
	logic [1:0]   vis_q, st_q, mask_q, bresp_q, st_set;
	logic         aw_have_q, w_have_q, aw_have_d, w_have_d;
	logic [7:0]   awaddr_q;
	logic [31:0]  wdata_q, rdata_q;
	logic [3:0]   wstrb_q;
	logic         awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic         do_write, write_ok, irq_clr;
	logic [15:0]  comp_q, comp_d, freq_q, lim_f;
	logic         hold_q, hold_d, active_q, active_d, irq_q;
	logic         enabled, over, no_limit;
	logic [25:0]  step;
	logic [16:0]  raw, sum;

	// Limit setting in 0.1 Hz scaled to 0.01 Hz frequency units
	function automatic logic [15:0] to_freq(input logic [15:0] lim);
		to_freq = 16'((lim << 3) + (lim << 1));
	endfunction : to_freq

	// Setting range check for a write of word d at offset a
	function automatic logic legal(input logic [7:0] a, input logic [31:0] d, input logic [1:0] v);
		legal = 1'b1;
		case (a)
			OFS_MODE:  legal = (v == 2'h0) && (d <= 32'(MODE_STEADY));
			OFS_THR:   legal = (v == 2'h0) && (d >= 32'(THR_MIN)) && (d <= 32'(THR_MAX));
			OFS_LIMIT: legal = (v == 2'h0) && ((d <= 32'(LIMIT_MAX)) || (d == 32'(LIMIT_NONE)));
			OFS_VGAIN: legal = (v == 2'h0) && (d <= 32'(GAIN_MAX));
			OFS_FGAIN: legal = (v == 2'h0) && (d <= 32'(GAIN_MAX));
			OFS_FMAX:  legal = (v == 2'h0);
			OFS_VIS, OFS_IRQST, OFS_MASK: legal = 1'b1;
			default:   legal = 1'b0;
		endcase
	endfunction : legal

	// Address and data hold flags, either order
	always_comb
	begin
		do_write  = aw_have_q && w_have_q && !bvalid_q;
		aw_have_d = (aw_have_q && !do_write) || (s_axi_awvalid && awready_q);
		w_have_d  = (w_have_q && !do_write) || (s_axi_wvalid && wready_q);
		write_ok  = legal(awaddr_q, wdata_q, vis_q) && (wstrb_q == 4'hf);
		irq_clr   = do_write && write_ok && (awaddr_q == OFS_IRQST);
	end

	// Write channel capture and response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready_q <= !aw_have_d;
			wready_q  <= !w_have_d;
			if (s_axi_awvalid && awready_q)
				awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
			if (s_axi_wvalid && wready_q)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= write_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Setting registers, locked unless visibility is zero; visibility and mask are always writable
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_q  <= '{RST_MODE, RST_THR, RST_LIMIT, RST_VGAIN, RST_FGAIN, RST_FMAX};
			vis_q  <= RST_VIS;
			mask_q <= 2'h0;
		end
		else if (do_write && write_ok)
		begin
			case (awaddr_q)
				OFS_MODE:  cfg_q.mode  <= wdata_q[1:0];
				OFS_THR:   cfg_q.thr   <= wdata_q[9:0];
				OFS_LIMIT: cfg_q.limit <= wdata_q[15:0];
				OFS_VGAIN: cfg_q.vgain <= wdata_q[7:0];
				OFS_FGAIN: cfg_q.fgain <= wdata_q[7:0];
				OFS_FMAX:  cfg_q.fmax  <= wdata_q[15:0];
				OFS_VIS:   vis_q       <= wdata_q[1:0];
				OFS_MASK:  mask_q      <= wdata_q[1:0];
				default:   mask_q      <= mask_q;
			endcase
		end
	end

	// Read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (rvalid_q)
		begin
			arready_q <= s_axi_rready;
			rvalid_q  <= !s_axi_rready;
		end
		else if (s_axi_arvalid && arready_q)
		begin
			arready_q   <= 1'b0;
			rvalid_q    <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			rdata_q     <= 32'h00000000;
			case ({s_axi_araddr[7:2], 2'b00})
				OFS_MODE:  rdata_q <= {30'h0, cfg_q.mode};
				OFS_THR:   rdata_q <= {22'h0, cfg_q.thr};
				OFS_LIMIT: rdata_q <= {16'h0, cfg_q.limit};
				OFS_VGAIN: rdata_q <= {24'h0, cfg_q.vgain};
				OFS_FGAIN: rdata_q <= {24'h0, cfg_q.fgain};
				OFS_FMAX:  rdata_q <= {16'h0, cfg_q.fmax};
				OFS_VIS:   rdata_q <= {30'h0, vis_q};
				OFS_STATE: rdata_q <= {comp_q, 14'h0, hold_q, active_q};
				OFS_IRQST: rdata_q <= {30'h0, st_q};
				OFS_MASK:  rdata_q <= {30'h0, mask_q};
				default:   s_axi_rresp <= RESP_SLVERR;
			endcase
		end
		else
			arready_q <= 1'b1;
	end

	// Enable, trigger and raise step per control cycle
	always_comb
	begin
		enabled  = (cfg_q.mode == MODE_ALWAYS)
			|| ((cfg_q.mode == MODE_STEADY) && ramp_status.steady);
		over     = bus_voltage >= cfg_q.thr;
		no_limit = cfg_q.limit == LIMIT_NONE;
		lim_f    = to_freq(cfg_q.limit);
		step     = (26'(over ? bus_voltage - cfg_q.thr : 10'h0) * 26'(cfg_q.vgain)
			* 26'(cfg_q.fgain)) / GAIN_DIV;
		if (over)
			raw = 17'(comp_q) + 17'(step[15:0]);
		else if (comp_q > DECAY_STEP)
			raw = 17'(comp_q - DECAY_STEP);
		else
			raw = 17'h0;
		if (raw[16])
			raw = 17'h0ffff;
		hold_d = hold_q;
		comp_d = raw[15:0];
		if (!enabled)
		begin
			comp_d = 16'h0;
			hold_d = 1'b0;
		end
		else if (no_limit)
			hold_d = 1'b0;
		else if (hold_q && (base_frequency <= 16'(lim_f >> 1)))
		begin
			hold_d = 1'b0;
			comp_d = (raw[15:0] > lim_f) ? lim_f : raw[15:0];
		end
		else if (hold_q || (ramp_status.decel && (raw[15:0] > lim_f)))
		begin
			hold_d = 1'b1;
			comp_d = lim_f;
		end
		else if (raw[15:0] > lim_f)
			comp_d = lim_f;
		active_d = enabled && (over || (comp_d != 16'h0));
		sum      = 17'(base_frequency) + 17'(comp_d);
		st_set   = {hold_d && !hold_q, active_d && !active_q};
	end

	// Compensation state, updated on each control sample
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			comp_q   <= 16'h0;
			hold_q   <= 1'b0;
			active_q <= 1'b0;
			freq_q   <= 16'h0;
		end
		else if (sample_tick)
		begin
			comp_q   <= comp_d;
			hold_q   <= hold_d;
			active_q <= active_d;
			freq_q   <= (sum > 17'(cfg_q.fmax)) ? cfg_q.fmax : sum[15:0];
		end
	end

	// Sticky events, set wins over a write-one clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q  <= 2'h0;
			irq_q <= 1'b0;
		end
		else
		begin
			st_q  <= (st_q & ~(irq_clr ? wdata_q[1:0] : 2'h0)) | (sample_tick ? st_set : 2'h0);
			irq_q <= |(st_q & mask_q);
		end
	end

	// Outputs straight from their flip-flops
	assign s_axi_awready         = awready_q;
	assign s_axi_wready          = wready_q;
	assign s_axi_bvalid          = bvalid_q;
	assign s_axi_bresp           = bresp_q;
	assign s_axi_arready         = arready_q;
	assign s_axi_rvalid          = rvalid_q;
	assign s_axi_rdata           = rdata_q;
	assign frequency_command     = freq_q;
	assign ov_stall_indication   = active_q;
	assign stall_alarm_output    = active_q;
	assign stall_prevent_request = active_q;
	assign irq                   = irq_q;

	property p_off;
		@(posedge aclk) disable iff (!aresetn)
		(sample_tick && cfg_q.mode == MODE_OFF) |=> (!active_q && comp_q == 16'h0);
	endproperty
	a_off: assert property (p_off) else $error("avoidance active with mode off");
	property p_raise;
		@(posedge aclk) disable iff (!aresetn)
		(sample_tick && enabled && over) |=> active_q && stall_alarm_output;
	endproperty
	a_raise: assert property (p_raise) else $error("no avoidance at threshold");
	property p_cap;
		@(posedge aclk) disable iff (!aresetn)
		(sample_tick && !no_limit) |=> comp_q <= $past(lim_f);
	endproperty
	a_cap: assert property (p_cap) else $error("compensation above limit");
	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
		(sample_tick && enabled && !no_limit && hold_q && base_frequency > 16'(lim_f >> 1))
			|=> hold_q && comp_q == $past(lim_f);
	endproperty
	a_hold: assert property (p_hold) else $error("deceleration hold released early");
	property p_fmax;
		@(posedge aclk) disable iff (!aresetn)
		sample_tick |=> frequency_command <= $past(cfg_q.fmax);
	endproperty
	a_fmax: assert property (p_fmax) else $error("frequency above maximum");
	property p_lock;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && vis_q != 2'h0 && awaddr_q == OFS_MODE)
			|=> $stable(cfg_q.mode) && s_axi_bvalid && (s_axi_bresp == RESP_SLVERR);
	endproperty
	a_lock: assert property (p_lock) else $error("locked setting written");
	property p_event;
		@(posedge aclk) disable iff (!aresetn)
		$rose(active_q) |-> st_q[ST_START] ##1 (irq == $past(mask_q[ST_START]) || st_q[ST_HOLD]);
	endproperty
	a_event: assert property (p_event) else $error("start event not flagged");
	property p_stall;
		@(posedge aclk) disable iff (!aresetn)
		$rose(stall_prevent_request) |-> $past(sample_tick && active_d);
	endproperty
	a_stall: assert property (p_stall) else $error("stall prevention without avoidance");
	property p_tick;
		@(posedge aclk) disable iff (!aresetn)
		!sample_tick |=> $stable(comp_q) && $stable(active_q);
	endproperty
	a_tick: assert property (p_tick) else $error("state changed between samples");
endmodule : rafc_top

// file: tb/rafc_power_stage.sv
// Power stage model: samples the DC bus voltage when asked.
// Assumes the bench drives fire and vdc on aclk.
module rafc_power_stage
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       fire,
	input  wire logic [9:0] vdc,
	output logic            sample_tick,
	output logic [9:0]      bus_voltage
);
	timeunit 1ns;
	timeprecision 1ns;
	// Strobe with the sample; value scrambles between samples
	always_ff @(posedge aclk)
	begin
		sample_tick <= aresetn & fire;
		bus_voltage <= fire ? vdc : ~bus_voltage;
	end
endmodule : rafc_power_stage

// file: tb/tb_regen_avoidance_freq_control.sv
// Bench for the regeneration avoidance block: bus, ticks, flags, interrupt.
// Assumes rafc_pkg and the power stage model are compiled first.
module tb_regen_avoidance_freq_control;
	timeunit 1ns;
	timeprecision 1ns;
	import rafc_pkg::*;
	localparam logic [2:0] ACC = 3'h4;
	localparam logic [2:0] STD = 3'h2;
	localparam logic [2:0] DEC = 3'h1;
	logic          aclk, aresetn, fire, sample_tick, irq;
	logic          s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic          ov_stall_indication, stall_alarm_output, stall_prevent_request;
	logic [1:0]    s_axi_bresp, s_axi_rresp;
	logic [3:0]    s_axi_wstrb;
	logic [7:0]    s_axi_awaddr, s_axi_araddr;
	logic [9:0]    bus_voltage, vdc;
	logic [15:0]   base_frequency, frequency_command;
	logic [31:0]   s_axi_wdata, s_axi_rdata;
	rafc_ramp_type ramp_status;
	int            miscompares = 0;
	int            n_tests = 0;

	// Block under test and the power stage beside it
	rafc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_tick, .bus_voltage,
		.base_frequency, .ramp_status, .frequency_command, .ov_stall_indication,
		.stall_alarm_output, .stall_prevent_request, .irq);
	rafc_power_stage i_stage (.aclk, .aresetn, .fire, .vdc, .sample_tick, .bus_voltage);

	// Clock
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic stop_test();
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask : chk

	// Bus write, held until each channel is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid & s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid & s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr

	// Bus read, data compared under a mask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0,
		input logic [31:0] m = 32'hffffffff);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid & s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata & m, e);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd

	// One control cycle through the power stage, outputs settled
	task automatic tick();
		@(posedge aclk);
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (2) @(posedge aclk);
		#1;
	endtask : tick

	// Mode, ramp and voltage for one tick, then flags and frequency
	task automatic step(input logic [1:0] m, input logic [2:0] r, input logic [9:0] v,
		input logic a, input logic [15:0] f);
		wr(OFS_MODE, {30'h0, m});
		ramp_status <= r;
		vdc <= v;
		tick();
		chk({29'h0, ov_stall_indication, stall_alarm_output, stall_prevent_request},
			{29'h0, {3{a}}});
		chk({16'h0, frequency_command}, {16'h0, f});
	endtask : step

	task automatic irq_chk(input logic e);
		@(posedge aclk);
		#1;
		chk({31'h0, irq}, {31'h0, e});
	endtask : irq_chk

	task automatic t_reset();
		rd(OFS_MODE, 32'h0);
		rd(OFS_THR, 32'h190);
		rd(OFS_LIMIT, 32'h3c);
		rd(OFS_VGAIN, 32'h64);
		rd(OFS_FGAIN, 32'h64);
		rd(OFS_FMAX, 32'h2ee0);
		rd(OFS_VIS, 32'h0);
		rd(OFS_MASK, 32'h0);
		rd(8'h28, 32'h0, RESP_SLVERR);
	endtask : t_reset

	task automatic t_modes();
		step(2'h0, ACC, 10'h19a, 1'b0, 16'h3e8);
		step(2'h1, ACC, 10'h19a, 1'b1, 16'h3f2);
		step(2'h2, ACC, 10'h19a, 1'b0, 16'h3e8);
		step(2'h2, STD, 10'h19a, 1'b1, 16'h3f2);
		step(2'h0, STD, 10'h19a, 1'b0, 16'h3e8);
		step(2'h1, ACC, 10'h190, 1'b1, 16'h3e8);
		step(2'h1, ACC, 10'h18f, 1'b0, 16'h3e8);
	endtask : t_modes

	task automatic t_cap();
		wr(OFS_LIMIT, 32'h2);
		step(2'h0, ACC, 10'h1a4, 1'b0, 16'h3e8);
		step(2'h1, ACC, 10'h1a4, 1'b1, 16'h3fc);
		step(2'h1, STD, 10'h1a4, 1'b1, 16'h3fc);
		wr(OFS_LIMIT, 32'h270f);
		step(2'h1, STD, 10'h1a4, 1'b1, 16'h410);
		wr(OFS_FMAX, 32'h406);
		step(2'h1, STD, 10'h1a4, 1'b1, 16'h406);
		wr(OFS_FMAX, 32'h2ee0);
		wr(OFS_LIMIT, 32'h3c);
	endtask : t_cap

	task automatic t_gain();
		step(2'h0, ACC, 10'h19a, 1'b0, 16'h3e8);
		wr(OFS_VGAIN, 32'hc8);
		wr(OFS_FGAIN, 32'h32);
		step(2'h1, ACC, 10'h19a, 1'b1, 16'h3f2);
		wr(OFS_VGAIN, 32'h0);
		step(2'h1, ACC, 10'h19a, 1'b1, 16'h3f2);
		wr(OFS_VGAIN, 32'hc8);
		wr(OFS_FGAIN, 32'hc8);
		step(2'h1, ACC, 10'h19a, 1'b1, 16'h41a);
		wr(OFS_VGAIN, 32'hc9, RESP_SLVERR);
		wr(OFS_FGAIN, 32'hc9, RESP_SLVERR);
		wr(OFS_VGAIN, 32'h64);
		wr(OFS_FGAIN, 32'h64);
	endtask : t_gain

	task automatic t_hold();
		wr(OFS_LIMIT, 32'h2);
		base_frequency <= 16'h64;
		step(2'h0, DEC, 10'h1c2, 1'b0, 16'h64);
		step(2'h1, DEC, 10'h1c2, 1'b1, 16'h78);
		rd(OFS_STATE, 32'h2, RESP_OKAY, 32'h2);
		base_frequency <= 16'hb;
		step(2'h1, DEC, 10'h1c2, 1'b1, 16'h1f);
		base_frequency <= 16'ha;
		tick();
		rd(OFS_STATE, 32'h0, RESP_OKAY, 32'h2);
		wr(OFS_LIMIT, 32'h3c);
		base_frequency <= 16'h3e8;
	endtask : t_hold

	task automatic t_lock();
		wr(OFS_VIS, 32'h1);
		wr(OFS_MODE, 32'h0, RESP_SLVERR);
		rd(OFS_MODE, 32'h1);
		wr(OFS_VIS, 32'h0);
		wr(OFS_THR, 32'h12b, RESP_SLVERR);
		wr(OFS_THR, 32'h321, RESP_SLVERR);
		wr(OFS_THR, 32'h320);
		wr(OFS_THR, 32'h12c);
		rd(OFS_THR, 32'h12c);
		wr(OFS_THR, 32'h190);
		s_axi_wstrb <= 4'h3;
		wr(OFS_THR, 32'h1f4, RESP_SLVERR);
		s_axi_wstrb <= 4'hf;
		rd(OFS_THR, 32'h190);
		wr(OFS_LIMIT, 32'h65, RESP_SLVERR);
		wr(OFS_STATE, 32'h0, RESP_SLVERR);
	endtask : t_lock

	task automatic t_irq();
		rd(OFS_IRQST, 32'h2, RESP_OKAY, 32'h2);
		step(2'h0, ACC, 10'h19a, 1'b0, 16'h3e8);
		wr(OFS_IRQST, 32'h3);
		wr(OFS_MASK, 32'h1);
		step(2'h1, ACC, 10'h19a, 1'b1, 16'h3f2);
		irq_chk(1'b1);
		rd(OFS_IRQST, 32'h1, RESP_OKAY, 32'h1);
		wr(OFS_MASK, 32'h0);
		irq_chk(1'b0);
		wr(OFS_MASK, 32'h1);
		irq_chk(1'b1);
		wr(OFS_IRQST, 32'h1);
		irq_chk(1'b0);
		rd(OFS_IRQST, 32'h0, RESP_OKAY, 32'h1);
	endtask : t_irq

	// Reset, then the scenarios in turn
	initial
	begin
		aresetn = 1'b0;
		fire = 1'b0;
		vdc = 10'h0;
		base_frequency = 16'h3e8;
		ramp_status = ACC;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_modes();
		t_cap();
		t_gain();
		t_hold();
		t_lock();
		t_irq();
		stop_test();
	end

	// Watchdog against a hung handshake
	initial
	begin
		#1000000;
		miscompares++;
		stop_test();
	end
endmodule : tb_regen_avoidance_freq_control
